/* core/rhi_core.sv */
// Interrupt service and host access timing of a serial real-time clock.
// Assumes the time counters live elsewhere and present their values here.
//
// Summary of operation
// - After a cold power-up the host must wait at least two seconds.
// - The oscillation-halt flag is 1 after cold power and 0 after backup.
// - Any seconds write clears all sub-second divider stages.
// - Writing 0 to the periodic flag withdraws the periodic request.
// - Cancel patterns in the alarm registers never match the time.
// - Level mode drives the periodic pin low until the flag is cleared.
// - Alarm flag writes of 1 do nothing, 0 releases the pin, enable kept.
`timescale 1ns/1ps
module rhi_core #(
   parameter int unsigned HALF_CYC    = rhi_pkg::HALF_SEC_CYC,
   parameter int unsigned POWERUP_CYC = rhi_pkg::POWERUP_CYC
) (
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire rhi_pkg::rhi_ctl_t   ctl,
   input  wire rhi_pkg::rhi_alarm_t alarm_w,
   input  wire rhi_pkg::rhi_alarm_t alarm_d,
   input  wire rhi_pkg::rhi_now_t   now,
   input  wire logic                sec_write,
   input  wire logic                periodic_flag_wr0,
   input  wire logic                week_flag_wr0,
   input  wire logic                daily_flag_wr0,
   input  wire logic                osc_halt_wr0,
   input  wire logic                osc_stopped,
   output rhi_pkg::rhi_flags_t      flags,
   output logic                     host_ready,
   output logic                     sec_tick,
   output logic                     periodic_irq_out_o,
   output logic                     periodic_irq_out_oe,
   output logic                     week_alarm_irq_out_o,
   output logic                     week_alarm_irq_out_oe,
   output logic                     daily_alarm_irq_out_o,
   output logic                     daily_alarm_irq_out_oe
);
   logic                          first_half;
   logic                          first_quarter;
   logic                          stop_s1_r;
   logic                          stop_s2_r;
   logic [rhi_pkg::PWR_CNT_W-1:0] pwr_cnt_r;
   logic [rhi_pkg::PWR_CNT_W-1:0] pwr_cnt_nxt;
   logic                          ready_r;
   logic                          ready_nxt;
   rhi_pkg::rhi_flags_t           flags_r;
   rhi_pkg::rhi_flags_t           flags_nxt;
   logic                          pin_a_r;
   logic                          pin_a_nxt;
   logic                          lvl_event;
   logic                          minute_edge;
   logic                          w_hit;
   logic                          d_hit;
   logic                          w_valid;
   logic                          d_valid;

   localparam logic [rhi_pkg::PWR_CNT_W-1:0] PWR_LAST =
      rhi_pkg::PWR_CNT_W'(POWERUP_CYC - 1);

   rhi_timebase #(
      .HALF_CYC (HALF_CYC)
   ) u_timebase (
      .core_clk      (core_clk),
      .rst_b         (rst_b),
      .sec_write     (sec_write),
      .sec_tick      (sec_tick),
      .first_half    (first_half),
      .first_quarter (first_quarter)
   );

   // The halt detector sits on the crystal side, so it is synchronised.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         stop_s1_r <= 1'b0;
         stop_s2_r <= 1'b0;
      end else begin
         stop_s1_r <= osc_stopped;
         stop_s2_r <= stop_s1_r;
      end
   end

   // Start-up wait; host_ready only informs, it cannot hold off the bus.
   always_comb begin
      pwr_cnt_nxt = pwr_cnt_r;
      ready_nxt   = ready_r;
      if (!ready_r) begin
         if (pwr_cnt_r == PWR_LAST) begin
            ready_nxt = 1'b1;
         end else begin
            pwr_cnt_nxt = pwr_cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pwr_cnt_r <= '0;
         ready_r   <= 1'b0;
      end else begin
         pwr_cnt_r <= pwr_cnt_nxt;
         ready_r   <= ready_nxt;
      end
   end

   // An invalid BCD minute or hour, as in the cancel patterns, never matches.
   function automatic logic alarm_ok(input rhi_pkg::rhi_alarm_t a);
      alarm_ok = (a.min <= rhi_pkg::MIN_MAX) &&
                 (a.min[3:0] <= rhi_pkg::DIGIT_MAX) &&
                 (a.hour <= rhi_pkg::HOUR_MAX) &&
                 (a.hour[3:0] <= rhi_pkg::DIGIT_MAX);
   endfunction

   assign w_valid     = alarm_ok(alarm_w);
   assign d_valid     = alarm_ok(alarm_d);
   assign minute_edge = sec_tick && now.sec_zero;
   assign w_hit = minute_edge && ctl.week_alarm_enable && w_valid &&
                  alarm_w.wday_mask[now.wday] &&
                  (alarm_w.hour == now.hour) && (alarm_w.min == now.min);
   assign d_hit = minute_edge && ctl.daily_alarm_enable && d_valid &&
                  (alarm_d.hour == now.hour) && (alarm_d.min == now.min);

   always_comb begin
      case (ctl.ct_sel)
         rhi_pkg::CT_LEVEL_SEC:   lvl_event = sec_tick;
         rhi_pkg::CT_LEVEL_MIN:   lvl_event = sec_tick && now.sec_zero;
         rhi_pkg::CT_LEVEL_HOUR:  lvl_event = sec_tick && now.sec_zero &&
                                              now.min_zero;
         rhi_pkg::CT_LEVEL_MONTH: lvl_event = sec_tick && now.sec_zero &&
                                              now.min_zero &&
                                              now.hour_zero && now.day_one;
         default:                 lvl_event = 1'b0;
      endcase
   end

   // Flags: a hardware set in the same cycle as a clear write wins.
   always_comb begin
      flags_nxt = flags_r;
      if (periodic_flag_wr0) begin
         flags_nxt.periodic_irq_flag = 1'b0;
      end
      if (lvl_event) begin
         flags_nxt.periodic_irq_flag = 1'b1;
      end
      if (week_flag_wr0) begin
         flags_nxt.week_alarm_flag = 1'b0;
      end
      if (w_hit) begin
         flags_nxt.week_alarm_flag = 1'b1;
      end
      if (daily_flag_wr0) begin
         flags_nxt.daily_alarm_flag = 1'b0;
      end
      if (d_hit) begin
         flags_nxt.daily_alarm_flag = 1'b1;
      end
      if (osc_halt_wr0) begin
         flags_nxt.osc_halt_flag = 1'b0;
      end
      if (stop_s2_r) begin
         flags_nxt.osc_halt_flag = 1'b1;
      end
   end

   // Reset models a cold start, so the halt flag comes up set.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flags_r.periodic_irq_flag <= rhi_pkg::FLAG_RST;
         flags_r.week_alarm_flag   <= rhi_pkg::FLAG_RST;
         flags_r.daily_alarm_flag  <= rhi_pkg::FLAG_RST;
         flags_r.osc_halt_flag     <= rhi_pkg::OSC_HALT_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Pin drive is registered so the open-drain enable never glitches.
   always_comb begin
      case (ctl.ct_sel)
         rhi_pkg::CT_OFF:       pin_a_nxt = 1'b0;
         rhi_pkg::CT_LOW:       pin_a_nxt = 1'b1;
         rhi_pkg::CT_PULSE_2HZ: pin_a_nxt = first_quarter;
         rhi_pkg::CT_PULSE_1HZ: pin_a_nxt = first_half;
         default: begin
            pin_a_nxt = flags_nxt.periodic_irq_flag;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_a_r <= 1'b0;
      end else begin
         pin_a_r <= pin_a_nxt;
      end
   end

   assign flags                  = flags_r;
   assign host_ready             = ready_r;
   assign periodic_irq_out_o     = 1'b0;
   assign periodic_irq_out_oe    = pin_a_r;
   assign week_alarm_irq_out_o   = 1'b0;
   assign week_alarm_irq_out_oe  = flags_r.week_alarm_flag;
   assign daily_alarm_irq_out_o  = 1'b0;
   assign daily_alarm_irq_out_oe = flags_r.daily_alarm_flag;
endmodule

/* core/rhi_pkg.sv */
// Package of constants and carriers for the RTC host access and interrupt
// service block.
// Assumes a single 25 MHz core clock and BCD time counters kept elsewhere.
package rhi_pkg;

   // Core clock rate and derived timing counts.
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned HALF_SEC_MS   = 500;
   localparam int unsigned POWERUP_MS    = 2000;
   localparam int unsigned HALF_SEC_CYC  = CLK_HZ / 1000 * HALF_SEC_MS;
   localparam int unsigned POWERUP_CYC   = CLK_HZ / 1000 * POWERUP_MS;
   localparam int unsigned HALF_CNT_W    = 24;
   localparam int unsigned PWR_CNT_W     = 26;

   // Periodic select codes.
   localparam logic [2:0] CT_OFF         = 3'h0;
   localparam logic [2:0] CT_LOW         = 3'h1;
   localparam logic [2:0] CT_PULSE_2HZ   = 3'h2;
   localparam logic [2:0] CT_PULSE_1HZ   = 3'h3;
   localparam logic [2:0] CT_LEVEL_SEC   = 3'h4;
   localparam logic [2:0] CT_LEVEL_MIN   = 3'h5;
   localparam logic [2:0] CT_LEVEL_HOUR  = 3'h6;
   localparam logic [2:0] CT_LEVEL_MONTH = 3'h7;

   // Reset values of control state.
   localparam logic       OSC_HALT_RST   = 1'h1;
   localparam logic       FLAG_RST       = 1'h0;

   // BCD limits used to reject unmatchable alarm settings.
   localparam logic [6:0] MIN_MAX        = 7'h59;
   localparam logic [5:0] HOUR_MAX       = 6'h23;
   localparam logic [3:0] DIGIT_MAX      = 4'h9;

   typedef struct packed {
      logic [2:0] ct_sel;
      logic       week_alarm_enable;
      logic       daily_alarm_enable;
   } rhi_ctl_t;

   typedef struct packed {
      logic [6:0] wday_mask;
      logic [5:0] hour;
      logic [6:0] min;
   } rhi_alarm_t;

   typedef struct packed {
      logic [2:0] wday;
      logic [5:0] hour;
      logic [6:0] min;
      logic       sec_zero;
      logic       min_zero;
      logic       hour_zero;
      logic       day_one;
   } rhi_now_t;

   typedef struct packed {
      logic periodic_irq_flag;
      logic week_alarm_flag;
      logic daily_alarm_flag;
      logic osc_halt_flag;
   } rhi_flags_t;

endpackage

/* core/rhi_timebase.sv */
// Half-second divider that times the sub-second stages of the clock.
// Assumes core_clk at the package rate; HALF_CYC may be shortened in sim.
`timescale 1ns/1ps
module rhi_timebase #(
   parameter int unsigned HALF_CYC = rhi_pkg::HALF_SEC_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic sec_write,
   output logic      sec_tick,
   output logic      first_half,
   output logic      first_quarter
);
   logic [rhi_pkg::HALF_CNT_W-1:0] cnt_r;
   logic [rhi_pkg::HALF_CNT_W-1:0] cnt_nxt;
   logic                           half_r;
   logic                           half_nxt;
   logic                           wrap;

   localparam logic [rhi_pkg::HALF_CNT_W-1:0] LAST =
      rhi_pkg::HALF_CNT_W'(HALF_CYC - 1);
   localparam logic [rhi_pkg::HALF_CNT_W-1:0] QUART =
      rhi_pkg::HALF_CNT_W'(HALF_CYC / 2);

   assign wrap          = (cnt_r == LAST);
   assign sec_tick      = wrap && half_r && !sec_write;
   assign first_half    = !half_r;
   assign first_quarter = (cnt_r < QUART);

   always_comb begin
      cnt_nxt  = wrap ? '0 : cnt_r + 1'b1;
      half_nxt = wrap ? !half_r : half_r;
      if (sec_write) begin
         // All fractional stages restart so the new second is full length.
         cnt_nxt  = '0;
         half_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt_r  <= '0;
         half_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         half_r <= half_nxt;
      end
   end
endmodule

/* bench/rhi_host_model.sv */
// Host-side model that services the periodic interrupt pin.
// Assumes an open-drain pin with a pull-up, so a released pin reads high.
`timescale 1ns/1ps
module rhi_host_model #(
   parameter int unsigned DLY = 3
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic irq_oe,
   input  wire logic auto_en,
   output logic      clr_o
);
   logic       irq_pin;
   logic [7:0] cnt_r;
   assign irq_pin = irq_oe ? 1'b0 : 1'b1;
   // Service ends far inside half a second, so reads stay in step.
   // Each service pulses clr_o once the pin has been low for DLY+1 cycles.
   always_ff @(posedge core_clk) begin
      if (!rst_b || !auto_en || irq_pin) begin
         cnt_r <= 8'h0;
         clr_o <= 1'b0;
      end else if (cnt_r == 8'(DLY)) begin
         cnt_r <= 8'h0;
         clr_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 8'h1;
         clr_o <= 1'b0;
      end
   end
endmodule

/* bench/rhi_core_asserts.sv */
// Port checker for the interrupt service block.
// Assumes it is bound into rhi_core and sees only its ports.
`timescale 1ns/1ps
module rhi_core_asserts #(
   parameter int unsigned HALF_CYC = rhi_pkg::HALF_SEC_CYC
) (
   input wire logic                core_clk,
   input wire logic                rst_b,
   input wire rhi_pkg::rhi_ctl_t   ctl,
   input wire rhi_pkg::rhi_alarm_t alarm_d,
   input wire logic                sec_write,
   input wire logic                periodic_flag_wr0,
   input wire logic                week_flag_wr0,
   input wire logic                daily_flag_wr0,
   input wire rhi_pkg::rhi_flags_t flags,
   input wire logic                host_ready,
   input wire logic                sec_tick,
   input wire logic                periodic_irq_out_oe,
   input wire logic                week_alarm_irq_out_oe,
   input wire logic                daily_alarm_irq_out_oe
);
   localparam int unsigned TICK = 2 * HALF_CYC;
   logic [31:0] since_wr_r;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge core_clk) begin
      if (!rst_b || sec_write || since_wr_r == TICK) begin
         since_wr_r <= {31'h0, rst_b & sec_write};
      end else if (since_wr_r != 32'h0) begin
         since_wr_r <= since_wr_r + 32'h1;
      end
   end
   property p_tick_quiet;
      since_wr_r != 32'h0 && since_wr_r < TICK |-> !sec_tick;
   endproperty
   a_tick_quiet: assert property (p_tick_quiet) else $error("early");
   property p_tick_due; since_wr_r == TICK |-> sec_tick; endproperty
   a_tick_due: assert property (p_tick_due) else $error("late tick");
   property p_tick_gap; sec_tick |=> (!sec_tick)[*8]; endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick gap");
   property p_per_set;
      sec_tick && ctl.ct_sel == rhi_pkg::CT_LEVEL_SEC
         |=> flags.periodic_irq_flag && periodic_irq_out_oe;
   endproperty
   a_per_set: assert property (p_per_set) else $error("no periodic");
   property p_per_hold;
      flags.periodic_irq_flag && !periodic_flag_wr0
         |=> flags.periodic_irq_flag;
   endproperty
   a_per_hold: assert property (p_per_hold) else $error("flag lost");
   property p_per_clr;
      periodic_flag_wr0 && !sec_tick && ctl.ct_sel[2]
         |=> !flags.periodic_irq_flag && !periodic_irq_out_oe;
   endproperty
   a_per_clr: assert property (p_per_clr) else $error("no clear");
   property p_week_clr;
      week_flag_wr0 && !sec_tick
         |=> !flags.week_alarm_flag && !week_alarm_irq_out_oe;
   endproperty
   a_week_clr: assert property (p_week_clr) else $error("week clr");
   property p_day_clr;
      daily_flag_wr0 && !sec_tick
         |=> !flags.daily_alarm_flag && !daily_alarm_irq_out_oe;
   endproperty
   a_day_clr: assert property (p_day_clr) else $error("daily clr");
   property p_cancel;
      sec_tick && alarm_d.hour > rhi_pkg::HOUR_MAX && !flags.daily_alarm_flag
         |=> !flags.daily_alarm_flag;
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel hit");
   property p_rst_vals;
      $rose(rst_b) |-> (flags == 4'h1 && !host_ready) ##1 (!host_ready)[*7];
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset vals");
   property p_ready_hold; host_ready |=> host_ready; endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready");
endmodule
bind rhi_core rhi_core_asserts #(.HALF_CYC(HALF_CYC)) chk_u (
   .core_clk, .rst_b, .ctl, .alarm_d, .sec_write, .periodic_flag_wr0,
   .week_flag_wr0, .daily_flag_wr0, .flags, .host_ready, .sec_tick,
   .periodic_irq_out_oe, .week_alarm_irq_out_oe, .daily_alarm_irq_out_oe);

/* bench/tb_top.sv */
// Self-checking bench for the interrupt service block.
// Assumes shortened counts; the host model clears the periodic flag.
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned HC = 8;
   localparam int unsigned PU = 20;
   logic                core_clk, rst_b, osc_stopped, auto_en, per_wr0;
   logic                host_ready, sec_tick;
   logic [3:0]          strb;
   logic [2:0]          oe;
   logic [2:0]          lo;
   logic [5:0]          mon;
   rhi_pkg::rhi_ctl_t   ctl;
   rhi_pkg::rhi_alarm_t alarm_w, alarm_d;
   rhi_pkg::rhi_now_t   now;
   rhi_pkg::rhi_flags_t flags;
   int                  n_mismatch, total_checks, n;
   assign mon = {host_ready, sec_tick, flags};
   rhi_core #(.HALF_CYC(HC), .POWERUP_CYC(PU)) dut_u (
      .core_clk, .rst_b, .ctl, .alarm_w, .alarm_d, .now,
      .sec_write(strb[0]), .periodic_flag_wr0(per_wr0),
      .week_flag_wr0(strb[1]), .daily_flag_wr0(strb[2]),
      .osc_halt_wr0(strb[3]), .osc_stopped, .flags, .host_ready,
      .sec_tick, .periodic_irq_out_o(lo[2]), .periodic_irq_out_oe(oe[2]),
      .week_alarm_irq_out_o(lo[1]), .week_alarm_irq_out_oe(oe[1]),
      .daily_alarm_irq_out_o(lo[0]), .daily_alarm_irq_out_oe(oe[0]));
   rhi_host_model host_u (.core_clk, .rst_b, .irq_oe(oe[2]), .auto_en,
      .clr_o(per_wr0));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_bit(input int sel, input logic val, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
      end while (mon[sel] !== val && k < 60);
      if (mon[sel] !== val) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic pulse(input int sel);
      @(posedge core_clk);
      strb[sel] <= 1'b1;
      @(posedge core_clk);
      strb[sel] <= 1'b0;
      #1;
   endtask
   task automatic t_reset();
      @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      #1;
      chk(flags, 32'h1);
      chk({host_ready, oe}, 32'h0);
      wait_bit(5, 1'b1, n);
      chk(32'(n >= PU - 1 && n <= PU), 32'h1);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         @(posedge core_clk);
         ctl.ct_sel <= 3'(m);
         repeat (2 * HC + 4) @(posedge core_clk);
         #1;
         chk(flags.periodic_irq_flag, 32'h0);
         if (m < 2) begin
            chk(oe[2], 32'(m));
         end else begin
            // Both pulse modes hold the pin low for half of every second.
            n = 0;
            repeat (2 * HC) begin
               @(posedge core_clk);
               #1;
               n += oe[2];
            end
            chk(n, HC);
         end
      end
   endtask
   task automatic t_sec_write();
      pulse(0);
      // The tick is combinational, so it shows one cycle before its edge.
      wait_bit(4, 1'b1, n);
      chk(n, 2 * HC - 1);
   endtask
   task automatic t_alarms();
      @(posedge core_clk);
      ctl <= '0;
      now <= {3'h2, 6'h12, 7'h30, 4'h8};
      alarm_w <= {7'h7f, 6'h12, 7'h30};
      alarm_d <= {7'h00, 6'h12, 7'h30};
      @(posedge core_clk);
      ctl <= 5'h3;
      wait_bit(2, 1'b1, n);
      chk({flags.daily_alarm_flag, oe[1:0]}, 32'h7);
      pulse(1);
      chk({flags[2], oe[1], flags[1]}, 32'h1);
      pulse(2);
      chk({flags.daily_alarm_flag, oe[0]}, 32'h0);
      wait_bit(2, 1'b1, n);
      chk(32'(n <= 2 * HC), 32'h1);
      @(posedge core_clk);
      ctl <= '0;
      alarm_w <= {7'h7f, 6'h3d, 7'h7d};
      alarm_d <= {7'h00, 6'h3e, 7'h7e};
      pulse(1);
      pulse(2);
      @(posedge core_clk);
      ctl <= 5'h3;
      repeat (4 * HC + 4) @(posedge core_clk);
      #1;
      chk({flags[2:1], oe[1:0]}, 32'h0);
   endtask
   task automatic t_osc();
      pulse(3);
      chk(flags.osc_halt_flag, 32'h0);
      @(posedge core_clk);
      osc_stopped <= 1'b1;
      wait_bit(0, 1'b1, n);
      chk(32'(n <= 4), 32'h1);
   endtask
   task automatic t_periodic();
      @(posedge core_clk);
      ctl.ct_sel <= rhi_pkg::CT_LEVEL_SEC;
      wait_bit(3, 1'b1, n);
      chk(oe[2], 32'h1);
      chk({lo, oe[2]}, 32'h1);
      repeat (2 * HC + 2) @(posedge core_clk);
      #1;
      chk({flags.periodic_irq_flag, oe[2]}, 32'h3);
      @(posedge core_clk);
      auto_en <= 1'b1;
      wait_bit(3, 1'b0, n);
      chk(oe[2], 32'h0);
   endtask
   task automatic t_level(input logic [2:0] sel, input logic [3:0] part,
                          input logic [3:0] full);
      wait_bit(3, 1'b0, n);
      @(posedge core_clk);
      ctl.ct_sel <= sel;
      now[3:0] <= part;
      n = 0;
      repeat (2 * HC + 2) begin
         @(posedge core_clk);
         #1;
         n += flags.periodic_irq_flag;
      end
      chk(n, 32'h0);
      @(posedge core_clk);
      now[3:0] <= full;
      wait_bit(3, 1'b1, n);
      chk(32'(n <= 2 * HC + 1), 32'h1);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      rst_b = 1'b0;
      ctl = '0;
      alarm_w = '0;
      alarm_d = '0;
      now = '0;
      strb = 4'h0;
      osc_stopped = 1'b0;
      auto_en = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (20) @(posedge core_clk);
      t_reset();
      t_modes();
      t_sec_write();
      t_alarms();
      t_osc();
      t_periodic();
      t_level(rhi_pkg::CT_LEVEL_MIN, 4'h0, 4'h8);
      t_level(rhi_pkg::CT_LEVEL_HOUR, 4'h8, 4'hc);
      t_level(rhi_pkg::CT_LEVEL_MONTH, 4'he, 4'hf);
      wrap_up();
   end
endmodule
